// ### core/bus_ue_mark_defines.svh
// Constants for the system data bus error-marking block.
// Assumes a 64-bit doubleword with an 8-bit check code beside it.
`ifndef BUS_UE_MARK_DEFINES_SVH
`define BUS_UE_MARK_DEFINES_SVH

// AXI4-Lite register byte offsets
`define OFF_STATUS 8'h00
`define OFF_MASK 8'h04
`define OFF_IDENTITY 8'h08
`define OFF_COUNTS 8'h0c
// Status and mask bit positions
`define BIT_RAW_FILL 0
`define BIT_IN_CORR 1
// Reset values
`define MASK_RESET 2'h0
`define IDENTITY_RESET 8'h00
// Check pattern that marks a word; tag sits in data bits 7:0
`define MARK_CHECK 8'hff
`define TAG_LSB 0
`define TAG_MEMORY 8'h00
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### core/bus_ue_mark_pkg.sv
// Types for the system data bus error-marking block.
// Assumes bus_ue_mark_defines.svh is compiled alongside.
package bus_ue_mark_pkg;
  typedef enum logic [1:0] {
    DEST_REG = 2'b00,
    DEST_IFETCH = 2'b01,
    DEST_LOAD = 2'b10,
    DEST_STORE = 2'b11
  } access_kind_t;
  typedef enum logic [1:0] {
    CLS_CLEAN = 2'b00,
    CLS_CORR = 2'b01,
    CLS_RAW_UE = 2'b10,
    CLS_MARKED = 2'b11
  } word_class_t;
endpackage

// ### core/bus_ue_mark.sv
// Error marking at the system data bus port: incoming and outgoing paths.
// Assumes SECDED check bits per doubleword and a core-clock AXI4-Lite master.
//
// Function
// - Marked incoming word forwarded unchanged, unreported.
// - Raw incoming UE marked with memory tag.
// - Cacheable incoming marking sets raw fill flag.
// - Noncacheable incoming marking reports nothing.
// - Noncacheable fetch UE traps at execution.
// - Noncacheable load UE traps at execution.
// - Cacheable fetch: L2 marked, L1I parity error.
// - Cacheable load/store: both caches marked, trap except on a doubleword store.
// - Marked outgoing word sent unchanged, unreported.
// - Raw outgoing UE marked with identity tag.
// - Outgoing noncacheable UE not reported locally.
// - Outgoing cacheable marked data delivered to destination.
// - Each doubleword carries SECDED check code.
// - Incoming single-bit error corrected, flag set.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bus_ue_mark_defines.svh"
`default_nettype none
module bus_ue_mark
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // Incoming doubleword from the bus
  input wire logic in_valid,
  input wire logic [63:0] in_data,
  input wire logic [7:0] in_check,
  input wire logic in_cacheable,
  input wire bus_ue_mark_pkg::access_kind_t in_kind,
  // Delivery to register or caches
  output logic dl_valid,
  output logic [63:0] dl_data,
  output logic [7:0] dl_check,
  output logic dl_to_reg,
  output logic dl_l2_fill,
  output logic dl_l1i_fill,
  output logic dl_l1i_parity_err,
  output logic dl_l1d_fill,
  output logic dl_poisoned,
  // Consumption of poisoned data by execution
  input wire logic exec_valid,
  input wire logic exec_poisoned,
  input wire bus_ue_mark_pkg::access_kind_t exec_kind,
  input wire logic exec_dw_store,
  output logic fetch_fault_trap,
  output logic ldst_fault_trap,
  output logic trap_marked_ue,
  // Outgoing doubleword to the bus
  input wire logic out_valid,
  input wire logic [63:0] out_data,
  input wire logic [7:0] out_check,
  input wire logic out_cacheable,
  output logic bus_valid,
  output logic [63:0] bus_data,
  output logic [7:0] bus_check,
  output logic bus_marked
);
  import bus_ue_mark_pkg::*;

  // ****************************************************************
  // SECDED helpers
  // ****************************************************************
  // Hsiao-style check: bit j covers data bits whose index has j set in a
  // spread code; kept simple so every port agrees on it.
  function automatic logic [7:0] gen_check(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++)
    begin
      logic [6:0] code;
      code = 7'(i) + 7'h01 + 7'((i + 1) >> 2) + 7'(i >= 56);
      for (int j = 0; j < 7; j++)
      begin
        if (code[j])
          c[j] = c[j] ^ d[i];
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction

  function automatic logic [6:0] col_code(input int i);
    return 7'(i) + 7'h01 + 7'((i + 1) >> 2) + 7'(i >= 56);
  endfunction

  // Classify a word; also returns the corrected data
  function automatic word_class_t classify(input logic [63:0] d, input logic [7:0] c,
                                           output logic [63:0] fixed);
    logic [7:0] syn;
    word_class_t cls;
    fixed = d;
    syn = gen_check(d) ^ c;
    // Top bit is the parity of the whole received word, so any single flipped
    // data bit reads as correctable whatever the weight of its column
    syn[7] = ^{d, c};
    if (c == `MARK_CHECK)
      cls = CLS_MARKED;
    else if (syn == 8'h00)
      cls = CLS_CLEAN;
    else if (syn[7])
    begin
      cls = CLS_CORR;
      for (int i = 0; i < 64; i++)
      begin
        if (col_code(i) == syn[6:0])
          fixed[i] = ~d[i];
      end
    end
    else
      cls = CLS_RAW_UE;
    return cls;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic aw_seen;
    logic [7:0] aw_addr;
    logic w_seen;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] identity;
    logic [15:0] raw_in_count;
    logic [15:0] raw_out_count;
    logic dl_valid;
    logic [63:0] dl_data;
    logic [7:0] dl_check;
    logic dl_to_reg;
    logic dl_l2;
    logic dl_l1i;
    logic dl_l1i_par;
    logic dl_l1d;
    logic dl_poison;
    logic fetch_trap;
    logic ldst_trap;
    logic bus_valid;
    logic [63:0] bus_data;
    logic [7:0] bus_check;
    logic bus_marked;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // Handshake readies stay combinational: one write outstanding at a time
  assign s_axi_awready = !st_reg.aw_seen && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.w_seen && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic [63:0] in_fixed;
    logic [63:0] out_fixed;
    word_class_t in_cls;
    word_class_t out_cls;
    logic [1:0] set_bits;
    logic [1:0] clr_bits;
    logic [7:0] wa;
    logic [7:0] ra;
    st_next = st_reg;
    in_fixed = 64'h0;
    out_fixed = 64'h0;
    set_bits = 2'h0;
    clr_bits = 2'h0;
    wa = 8'h00;
    ra = 8'h00;
    in_cls = classify(in_data, in_check, in_fixed);
    out_cls = classify(out_data, out_check, out_fixed);

    // Incoming path: one cycle from bus to delivery
    st_next.dl_valid = in_valid;
    st_next.dl_to_reg = in_valid && (in_kind == DEST_REG || !in_cacheable);
    st_next.dl_l2 = in_valid && in_cacheable && in_kind != DEST_REG;
    st_next.dl_l1i = in_valid && in_cacheable && in_kind == DEST_IFETCH;
    st_next.dl_l1d = in_valid && in_cacheable &&
                     (in_kind == DEST_LOAD || in_kind == DEST_STORE);
    st_next.dl_poison = in_valid && (in_cls == CLS_RAW_UE || in_cls == CLS_MARKED);
    st_next.dl_l1i_par = 1'b0;
    case (in_cls)
      CLS_MARKED:
      begin
        st_next.dl_data = in_data;
        st_next.dl_check = in_check;
      end
      CLS_RAW_UE:
      begin
        st_next.dl_data = in_data;
        st_next.dl_data[`TAG_LSB +: 8] = `TAG_MEMORY;
        st_next.dl_check = `MARK_CHECK;
        if (in_valid && in_cacheable)
          set_bits[`BIT_RAW_FILL] = 1'b1;
        // Noncacheable marking leaves status untouched
      end
      CLS_CORR:
      begin
        st_next.dl_data = in_fixed;
        st_next.dl_check = gen_check(in_fixed);
        if (in_valid)
          set_bits[`BIT_IN_CORR] = 1'b1;
      end
      default:
      begin
        st_next.dl_data = in_data;
        st_next.dl_check = in_check;
      end
    endcase
    // L1 instruction cache cannot hold a mark: poison its parity
    st_next.dl_l1i_par = st_next.dl_l1i && st_next.dl_poison;
    if (in_valid && in_cls == CLS_RAW_UE)
      st_next.raw_in_count = st_reg.raw_in_count + 16'h0001;

    // Deferred traps on consumption of poisoned data
    st_next.fetch_trap = exec_valid && exec_poisoned && exec_kind == DEST_IFETCH;
    st_next.ldst_trap = exec_valid && exec_poisoned &&
                        (exec_kind == DEST_LOAD ||
                         (exec_kind == DEST_STORE && !exec_dw_store));

    // Outgoing path: never reports locally
    st_next.bus_valid = out_valid;
    st_next.bus_marked = out_valid && (out_cls == CLS_RAW_UE || out_cls == CLS_MARKED);
    case (out_cls)
      CLS_MARKED:
      begin
        st_next.bus_data = out_data;
        st_next.bus_check = out_check;
      end
      CLS_RAW_UE:
      begin
        st_next.bus_data = out_data;
        st_next.bus_data[`TAG_LSB +: 8] = st_reg.identity;
        st_next.bus_check = `MARK_CHECK;
      end
      CLS_CORR:
      begin
        st_next.bus_data = out_fixed;
        st_next.bus_check = gen_check(out_fixed);
      end
      default:
      begin
        st_next.bus_data = out_data;
        st_next.bus_check = out_check;
      end
    endcase
    if (out_valid && out_cls == CLS_RAW_UE)
      st_next.raw_out_count = st_reg.raw_out_count + 16'h0001;

    // AXI write: address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_seen = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_seen = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_seen && st_reg.w_seen)
    begin
      wa = {st_reg.aw_addr[7:2], 2'b00};
      st_next.aw_seen = 1'b0;
      st_next.w_seen = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `RESP_OKAY;
      if (wa == `OFF_STATUS)
      begin
        if (st_reg.w_strb[0])
          clr_bits = st_reg.w_data[1:0];
      end
      else if (wa == `OFF_MASK)
      begin
        if (st_reg.w_strb[0])
          st_next.mask = st_reg.w_data[1:0];
      end
      else if (wa == `OFF_IDENTITY)
      begin
        if (st_reg.w_strb[0])
          st_next.identity = st_reg.w_data[7:0];
      end
      else if (wa == `OFF_COUNTS)
        st_next.bresp = `RESP_OKAY; // Read-only counters ignore writes
      else
        st_next.bresp = `RESP_SLVERR;
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    // Set wins over a write-one clear in the same cycle
    st_next.status = (st_reg.status & ~clr_bits) | set_bits;

    // AXI read
    if (s_axi_arvalid && s_axi_arready)
    begin
      ra = {s_axi_araddr[7:2], 2'b00};
      st_next.rvalid = 1'b1;
      st_next.rresp = `RESP_OKAY;
      if (ra == `OFF_STATUS)
        st_next.rdata = {30'h0, st_reg.status};
      else if (ra == `OFF_MASK)
        st_next.rdata = {30'h0, st_reg.mask};
      else if (ra == `OFF_IDENTITY)
        st_next.rdata = {24'h0, st_reg.identity};
      else if (ra == `OFF_COUNTS)
        st_next.rdata = {st_reg.raw_out_count, st_reg.raw_in_count};
      else
      begin
        st_next.rdata = 32'h0;
        st_next.rresp = `RESP_SLVERR;
      end
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.mask <= `MASK_RESET;
      st_reg.identity <= `IDENTITY_RESET;
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from flip-flops, except irq and trap_marked_ue, which are gated from them
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign irq = |(st_reg.status & st_reg.mask);
  assign dl_valid = st_reg.dl_valid;
  assign dl_data = st_reg.dl_data;
  assign dl_check = st_reg.dl_check;
  assign dl_to_reg = st_reg.dl_to_reg;
  assign dl_l2_fill = st_reg.dl_l2;
  assign dl_l1i_fill = st_reg.dl_l1i;
  assign dl_l1i_parity_err = st_reg.dl_l1i_par;
  assign dl_l1d_fill = st_reg.dl_l1d;
  assign dl_poisoned = st_reg.dl_poison;
  assign fetch_fault_trap = st_reg.fetch_trap;
  assign ldst_fault_trap = st_reg.ldst_trap;
  assign trap_marked_ue = st_reg.fetch_trap | st_reg.ldst_trap;
  assign bus_valid = st_reg.bus_valid;
  assign bus_data = st_reg.bus_data;
  assign bus_check = st_reg.bus_check;
  assign bus_marked = st_reg.bus_marked;
endmodule
`default_nettype wire

// ### testbench/bus_ue_mark_monitor.sv
// Checker for the bus error-marking block.
// Assumes it is bound to bus_ue_mark and sees only its ports.
`timescale 1ns/1ps
`include "bus_ue_mark_defines.svh"
`default_nettype none
module bus_ue_mark_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire logic [63:0] in_data,
  input wire logic [7:0] in_check,
  input wire logic in_cacheable,
  input wire logic dl_valid,
  input wire logic [63:0] dl_data,
  input wire logic [7:0] dl_check,
  input wire logic dl_to_reg,
  input wire logic dl_l2_fill,
  input wire logic dl_l1i_fill,
  input wire logic dl_l1i_parity_err,
  input wire logic dl_poisoned,
  input wire logic exec_valid,
  input wire logic exec_poisoned,
  input wire bus_ue_mark_pkg::access_kind_t exec_kind,
  input wire logic exec_dw_store,
  input wire logic fetch_fault_trap,
  input wire logic ldst_fault_trap,
  input wire logic out_valid,
  input wire logic [63:0] out_data,
  input wire logic [7:0] out_check,
  input wire logic bus_valid,
  input wire logic [63:0] bus_data,
  input wire logic [7:0] bus_check,
  input wire logic bus_marked
);
  import bus_ue_mark_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_marked_in:
  assert property (in_valid && in_check == `MARK_CHECK |=> dl_valid && dl_poisoned
    && dl_data == $past(in_data) && dl_check == `MARK_CHECK) else $error("marked word altered");
  chk_nc_to_reg:
  assert property (in_valid && !in_cacheable |=> dl_valid && dl_to_reg && !dl_l2_fill)
    else $error("noncacheable word not sent to register");
  chk_l1i_parity:
  assert property (dl_valid && dl_l1i_fill && dl_poisoned |-> dl_l1i_parity_err)
    else $error("poisoned fetch fill lacks parity error");
  chk_fetch_trap:
  assert property (exec_valid && exec_poisoned && exec_kind == DEST_IFETCH |=> fetch_fault_trap)
    else $error("fetch trap missing");
  chk_load_trap:
  assert property (exec_valid && exec_poisoned && exec_kind == DEST_LOAD
    |=> ldst_fault_trap && !fetch_fault_trap) else $error("load trap missing");
  chk_dw_store:
  assert property (exec_valid && exec_poisoned && exec_kind == DEST_STORE && exec_dw_store
    |=> !ldst_fault_trap) else $error("doubleword store trapped");
  chk_marked_out:
  assert property (out_valid && out_check == `MARK_CHECK |=> bus_valid && bus_marked
    && bus_data == $past(out_data)) else $error("marked outgoing word altered");
  chk_out_check:
  assert property (bus_valid && bus_marked |-> bus_check == `MARK_CHECK)
    else $error("marked outgoing word lacks marker");
  // Main scenarios reached
  cover property (in_valid && in_cacheable && in_check == `MARK_CHECK);
  cover property (exec_valid && exec_poisoned && exec_dw_store);
  cover property (out_valid && out_check != `MARK_CHECK);
endmodule
bind bus_ue_mark bus_ue_mark_monitor bus_ue_mark_monitor_i
(
  .aclk(aclk), .aresetn(aresetn), .in_valid(in_valid), .in_data(in_data),
  .in_check(in_check), .in_cacheable(in_cacheable), .dl_valid(dl_valid), .dl_data(dl_data),
  .dl_check(dl_check), .dl_to_reg(dl_to_reg), .dl_l2_fill(dl_l2_fill),
  .dl_l1i_fill(dl_l1i_fill), .dl_l1i_parity_err(dl_l1i_parity_err),
  .dl_poisoned(dl_poisoned), .exec_valid(exec_valid), .exec_poisoned(exec_poisoned),
  .exec_kind(exec_kind), .exec_dw_store(exec_dw_store), .fetch_fault_trap(fetch_fault_trap),
  .ldst_fault_trap(ldst_fault_trap), .out_valid(out_valid), .out_data(out_data),
  .out_check(out_check), .bus_valid(bus_valid), .bus_data(bus_data),
  .bus_check(bus_check), .bus_marked(bus_marked)
);
`default_nettype wire

// ### testbench/bus_peer_model.sv
// Far side of the system data bus: sends doublewords in, takes words out.
// Assumes the caller starts each send just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module bus_peer_model
(
  input wire logic aclk,
  output logic in_valid,
  output logic [63:0] in_data,
  output logic [7:0] in_check,
  output logic in_cacheable,
  output var bus_ue_mark_pkg::access_kind_t in_kind,
  input wire logic bus_valid,
  input wire logic [63:0] bus_data
);
  import bus_ue_mark_pkg::*;
  logic [63:0] rx_data;
  initial
  begin
    in_valid = 1'b0;
    in_data = 64'h0;
    in_check = 8'h00;
    in_cacheable = 1'b0;
    in_kind = DEST_REG;
  end
  // One word with its check code for one cycle; released lines are scrambled
  task automatic send(input logic [63:0] d, input logic [7:0] c, input logic ca,
    input access_kind_t k);
    @(posedge aclk);
    in_valid <= 1'b1;
    in_data <= d;
    in_check <= c;
    in_cacheable <= ca;
    in_kind <= k;
    @(posedge aclk);
    in_valid <= 1'b0;
    in_data <= ~d; // Stale data must not look valid
    in_check <= ~c;
  endtask
  // Destination port keeps what arrives; it owns the later report
  always @(posedge aclk)
    if (bus_valid)
      rx_data <= bus_data;
endmodule
`default_nettype wire

// ### testbench/system_bus_ue_error_marking_test.sv
// Self-checking bench for the bus error-marking block.
// Assumes the defines header on the include path; one 50 MHz clock.
`timescale 1ns/1ps
`include "bus_ue_mark_defines.svh"
`default_nettype none
module system_bus_ue_error_marking_test;
  import bus_ue_mark_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic in_valid, in_cacheable, dl_valid, dl_to_reg, dl_l2_fill, dl_l1i_fill;
  logic dl_l1i_parity_err, dl_l1d_fill, dl_poisoned, bus_valid, bus_marked;
  logic [63:0] in_data, dl_data, out_data = 64'h0, bus_data;
  logic [7:0] in_check, dl_check, out_check = 8'h00, bus_check;
  access_kind_t in_kind, exec_kind = DEST_REG;
  logic exec_valid = 1'b0, exec_poisoned = 1'b0, exec_dw_store = 1'b0;
  logic out_valid = 1'b0, out_cacheable = 1'b0;
  logic fetch_fault_trap, ldst_fault_trap, trap_marked_ue;
  int miscompares = 0, cmp_count = 0;
  always #10 aclk = ~aclk;
  bus_ue_mark bus_ue_mark_i
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .in_valid(in_valid), .in_data(in_data), .in_check(in_check),
    .in_cacheable(in_cacheable), .in_kind(in_kind),
    .dl_valid(dl_valid), .dl_data(dl_data), .dl_check(dl_check), .dl_to_reg(dl_to_reg),
    .dl_l2_fill(dl_l2_fill), .dl_l1i_fill(dl_l1i_fill), .dl_l1i_parity_err(dl_l1i_parity_err),
    .dl_l1d_fill(dl_l1d_fill), .dl_poisoned(dl_poisoned),
    .exec_valid(exec_valid), .exec_poisoned(exec_poisoned), .exec_kind(exec_kind),
    .exec_dw_store(exec_dw_store), .fetch_fault_trap(fetch_fault_trap),
    .ldst_fault_trap(ldst_fault_trap), .trap_marked_ue(trap_marked_ue),
    .out_valid(out_valid), .out_data(out_data), .out_check(out_check),
    .out_cacheable(out_cacheable), .bus_valid(bus_valid), .bus_data(bus_data),
    .bus_check(bus_check), .bus_marked(bus_marked)
  );
  bus_peer_model bus_peer_model_i
  (
    .aclk(aclk), .in_valid(in_valid), .in_data(in_data), .in_check(in_check),
    .in_cacheable(in_cacheable), .in_kind(in_kind), .bus_valid(bus_valid), .bus_data(bus_data)
  );
  // ****************
  // Helpers
  // ****************
  // Own copy of the check code, kept apart from the design's
  function automatic logic [7:0] ecc(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++)
      if (d[i])
        c[6:0] = c[6:0] ^ 7'(i + 1 + ((i + 1) >> 2) + (i >= 56));
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic see_dl(input logic [63:0] d, input logic [7:0] c, input logic [6:0] f);
    @(negedge aclk);
    cmp("dl_data", d, dl_data);
    cmp("dl_check", {56'h0, c}, {56'h0, dl_check});
    cmp("dl_flags", {57'h0, f}, {57'h0, dl_valid, dl_to_reg, dl_l2_fill, dl_l1i_fill,
      dl_l1i_parity_err, dl_l1d_fill, dl_poisoned});
  endtask
  task automatic out_see(input logic [63:0] d, input logic [7:0] c, input logic ca,
    input logic [63:0] e);
    @(posedge aclk);
    out_valid <= 1'b1;
    out_data <= d;
    out_check <= c;
    out_cacheable <= ca;
    @(posedge aclk);
    out_valid <= 1'b0;
    out_data <= ~d;
    @(negedge aclk);
    cmp("bus_word", e, bus_data);
    cmp("bus_mark", {1'b1, 1'b1, `MARK_CHECK}, {bus_valid, bus_marked, bus_check});
    @(negedge aclk);
    cmp("rx_word", e, bus_peer_model_i.rx_data);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    axr(`OFF_MASK);
    cmp("mask", 64'(`MASK_RESET), 64'(rd));
    axw(`OFF_IDENTITY, 32'h5a);
    cmp("bresp", 64'(`RESP_OKAY), 64'(rsp));
    axr(`OFF_IDENTITY);
    cmp("identity", 64'h5a, 64'(rd));
    axr(8'h10);
    cmp("unmapped", 64'(`RESP_SLVERR), 64'(rsp));
  endtask
  // Raw words over every kind, cacheable and not
  task automatic t_in_raw;
    logic [63:0] d;
    logic c;
    logic [1:0] k;
    for (int n = 0; n < 8; n++)
    begin
      d = 64'h0123456789abcdef + 64'(n);
      c = n[2];
      k = n[1:0];
      bus_peer_model_i.send(d, ecc(d) ^ 8'h03, c, access_kind_t'(k));
      see_dl({d[63:8], `TAG_MEMORY}, `MARK_CHECK, {1'b1, !c || k == 0, c && k != 0,
        c && k == 1, c && k == 1, c && k[1], 1'b1});
      axr(`OFF_STATUS);
      cmp("status", 64'(c), 64'(rd));
      axw(`OFF_STATUS, 32'h3);
    end
  endtask
  task automatic t_in_marked;
    logic [63:0] d;
    d = 64'h0123456789abcdef;
    axw(`OFF_MASK, 32'h3);
    bus_peer_model_i.send(64'hfeed000000000042, `MARK_CHECK, 1'b1, DEST_LOAD);
    see_dl(64'hfeed000000000042, `MARK_CHECK, 7'b1010011);
    bus_peer_model_i.send(d ^ 64'h20, ecc(d), 1'b1, DEST_LOAD);
    see_dl(d, ecc(d), 7'b1010010);
    axr(`OFF_STATUS);
    cmp("status_irq", 64'h5, 64'({rd, irq}));
    axw(`OFF_STATUS, 32'h2);
    @(negedge aclk);
    cmp("irq", 64'h0, 64'(irq));
  endtask
  task automatic t_out;
    logic [63:0] d;
    d = 64'hcafe0123456789ab;
    out_see(d, ecc(d) ^ 8'h05, 1'b0, {d[63:8], 8'h5a});
    out_see(d, `MARK_CHECK, 1'b1, d);
    axr(`OFF_STATUS);
    cmp("status", 64'h0, 64'(rd));
    axr(`OFF_COUNTS);
    cmp("counts", 64'h0001_0008, 64'(rd));
  endtask
  // Table: kind, doubleword store, poisoned, expected fetch and load/store trap
  task automatic t_exec;
    logic [5:0] tbl [5] = '{6'b01_0_1_10, 6'b10_0_1_01, 6'b11_0_1_01, 6'b11_1_1_00,
      6'b10_0_0_00};
    for (int n = 0; n < 5; n++)
    begin
      @(posedge aclk);
      exec_valid <= 1'b1;
      exec_kind <= access_kind_t'(tbl[n][5:4]);
      exec_dw_store <= tbl[n][3];
      exec_poisoned <= tbl[n][2];
      @(posedge aclk);
      exec_valid <= 1'b0;
      @(negedge aclk);
      cmp("traps", {tbl[n][1:0], |tbl[n][1:0]}, {fetch_fault_trap, ldst_fault_trap,
        trap_marked_ue});
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence after 16 cycles of reset
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_in_raw;
    t_in_marked;
    t_out;
    t_exec;
    give_verdict;
  end
  // Watchdog: the scenarios need well under a thousand cycles
  initial
  begin
    #(5000 * 20);
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
